// file: src/bsa_pkg.sv
// constants and types shared by the black stretch and alpha setup block
package bsa_pkg;

   // ----------------------------------------------------------------
   // structure
   // ----------------------------------------------------------------
   localparam int NUM_CH     = 2;
   localparam int NUM_IMP    = 2;
   localparam int NUM_GLAYER = 4;

   // ----------------------------------------------------------------
   // field widths
   // ----------------------------------------------------------------
   localparam int START_W = 4;
   localparam int DEPTH_W = 4;
   localparam int TC1_W   = 5;
   localparam int TC2_W   = 5;
   localparam int ALPHA_W = 8;
   localparam int PARAM_W = START_W + DEPTH_W + TC1_W + TC2_W;
   localparam int LIDX_W  = 2;

   // ----------------------------------------------------------------
   // limits and values after reset
   // ----------------------------------------------------------------
   localparam logic [TC2_W-1:0]   TC2_MAX      = 5'h1e;
   localparam logic               STRETCH_RST  = 1'h0;
   localparam logic [PARAM_W-1:0] PARAM_RST    = 18'h00000;
   localparam logic [ALPHA_W-1:0] ALPHA_RST    = 8'h00;
   localparam logic [ALPHA_W-1:0] ALPHA_OPAQUE = 8'hff;
   localparam logic               PREMUL_RST   = 1'h0;
   localparam logic [LIDX_W-1:0]  BASE_LAYER   = 2'h0;

   // ----------------------------------------------------------------
   // setup commands and answers
   // ----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      CMD_STRETCH_ON    = 4'h1,
      CMD_STRETCH_PARAM = 4'h2,
      CMD_ALPHA_1BIT    = 4'h4,
      CMD_PREMUL        = 4'h8
   } bsa_cmd_t;

   typedef enum logic [2:0]
   {
      ERR_NONE      = 3'h0,
      ERR_GRAPHICS_LAYER_INDEX  = 3'h1,
      ERR_RANGE     = 3'h2,
      ERR_IF_COND   = 3'h3,
      ERR_RESOURCE  = 3'h4,
      ERR_UNDEFINED = 3'h5
   } bsa_err_t;

endpackage

// file: src/bsa_shadow.sv
// one setting held as pending value and frame-aligned active value
`timescale 1ns/100ps
module bsa_shadow
#(
   parameter int             W       = 8,
   parameter logic [W-1:0]   RST_VAL = '0
)
(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // update
   input  wire logic         load,
   input  wire logic [W-1:0] loadData,
   input  wire logic         commit,
   // state
   output wire logic [W-1:0] activeVal,
   output wire logic         pending
);

   typedef struct packed
   {
      logic [W-1:0] pend;
      logic         pendValid;
      logic [W-1:0] active;
   } bsa_shadow_st_t;

   bsa_shadow_st_t shadow_reg;
   bsa_shadow_st_t shadow_next;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // a write in the commit cycle is kept for the next frame, not lost
   always_comb
   begin
      shadow_next = shadow_reg;
      if (commit && shadow_reg.pendValid)
      begin
         shadow_next.active    = shadow_reg.pend;
         shadow_next.pendValid = 1'b0;
      end
      if (load)
      begin
         shadow_next.pend      = loadData;
         shadow_next.pendValid = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         shadow_reg.pend      <= RST_VAL;
         shadow_reg.pendValid <= 1'b0;
         shadow_reg.active    <= RST_VAL;
      end
      else
      begin
         shadow_reg <= shadow_next;
      end
   end

   assign activeVal = shadow_reg.active;
   assign pending   = shadow_reg.pendValid;

endmodule

// file: src/bsa_setup.sv
// black stretch and one-bit alpha setup for two display channels
//
// Behaviour
// - two channels, each with own settings, chosen by channel index 0 or 1.
// - improver 0 serves layer 0 reads, improver 1 serves layer 1 reads.
// - enable and parameters written separately; kept until reset or rewrite.
// - start point per improver, 0 to 15, resets to zero.
// - depth per improver, 0 to 15, resets to zero.
// - first time constant per improver, 0 to 31, resets to zero.
// - second time constant per improver, 0 to 30, resets to zero.
// - layers 1 to 3: alpha bit 0 maps to programmable 8-bit value.
// - layers 1 to 3: alpha bit 1 maps to programmable 8-bit value.
// - layer 0 and output generator one-bit alpha fixed at 255.
// - layers 1 to 3: premultiply on/off control, reset to off; layer 0 fixed off.
`timescale 1ns/100ps
module bsa_setup
#(
   parameter int NUM_CH     = bsa_pkg::NUM_CH,
   parameter int NUM_IMP    = bsa_pkg::NUM_IMP,
   parameter int NUM_GLAYER = bsa_pkg::NUM_GLAYER
)
(
   // clock and reset
   input  wire logic                                 mclk,
   input  wire logic                                 rst_n,
   // frame timing, one pulse per channel frame start
   input  wire logic [NUM_CH-1:0]                    frameStart,
   // read path state per channel and layer
   input  wire logic [NUM_CH-1:0][NUM_GLAYER-1:0]    layerEnabled,
   input  wire logic [NUM_CH-1:0][NUM_GLAYER-1:0]    layerFmtYcc,
   // setup command
   input  wire logic                                 cfgWrite,
   input  wire bsa_pkg::bsa_cmd_t                    cfgCmd,
   input  wire logic                                 cfgChannel,
   input  wire logic                                 qualityImproverIndex,
   input  wire logic [bsa_pkg::LIDX_W-1:0]           graphicsLayerIndex,
   input  wire logic                                 cfgStretchOn,
   input  wire logic [bsa_pkg::START_W-1:0]          darkExpandStartPoint,
   input  wire logic [bsa_pkg::DEPTH_W-1:0]          darkExpandDepth,
   input  wire logic [bsa_pkg::TC1_W-1:0]            darkExpandTimeConstFirst,
   input  wire logic [bsa_pkg::TC2_W-1:0]            darkExpandTimeConstSecond,
   input  wire logic [bsa_pkg::ALPHA_W-1:0]          oneBitAlphaZeroValue,
   input  wire logic [bsa_pkg::ALPHA_W-1:0]          oneBitAlphaOneValue,
   input  wire logic                                 premultiplyEnable,
   // setup answer
   output wire logic                                 cfgDone,
   output wire bsa_pkg::bsa_err_t                    cfgError,
   output wire logic [NUM_CH-1:0]                    updatePending,
   // applied black stretch settings
   output wire logic [NUM_CH-1:0][NUM_IMP-1:0]       stretchOn,
   output wire logic [NUM_CH-1:0][NUM_IMP-1:0]
                     [bsa_pkg::START_W-1:0]          stretchStart,
   output wire logic [NUM_CH-1:0][NUM_IMP-1:0]
                     [bsa_pkg::DEPTH_W-1:0]          stretchDepth,
   output wire logic [NUM_CH-1:0][NUM_IMP-1:0]
                     [bsa_pkg::TC1_W-1:0]            stretchTc1,
   output wire logic [NUM_CH-1:0][NUM_IMP-1:0]
                     [bsa_pkg::TC2_W-1:0]            stretchTc2,
   // applied alpha settings, layer 0 fixed
   output wire logic [NUM_CH-1:0][NUM_GLAYER-1:0]
                     [bsa_pkg::ALPHA_W-1:0]          alphaZero,
   output wire logic [NUM_CH-1:0][NUM_GLAYER-1:0]
                     [bsa_pkg::ALPHA_W-1:0]          alphaOne,
   output wire logic [NUM_CH-1:0][NUM_GLAYER-1:0]    premulOn,
   output wire logic [bsa_pkg::ALPHA_W-1:0]          outGenAlpha
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic                                done;
      bsa_pkg::bsa_err_t                   err;
      logic [NUM_CH-1:0]                   pendAny;
      logic [NUM_CH-1:0][NUM_IMP-1:0]      gatedOn;
      logic [bsa_pkg::ALPHA_W-1:0]         opaque;
      logic [NUM_CH-1:0]                   premulBase;
   } bsa_setup_st_t;

   bsa_setup_st_t setup_reg;
   bsa_setup_st_t setup_next;

   // ----------------------------------------------------------------
   // load strobes and shadow outputs
   // ----------------------------------------------------------------
   logic [NUM_CH-1:0][NUM_IMP-1:0]                     loadOn;
   logic [NUM_CH-1:0][NUM_IMP-1:0]                     loadPar;
   logic [NUM_CH-1:0][NUM_GLAYER-1:0]                  loadAlpha;
   logic [NUM_CH-1:0][NUM_GLAYER-1:0]                  loadPremul;
   logic [NUM_CH-1:0][NUM_IMP-1:0]                     rawOn;
   logic [NUM_CH-1:0][NUM_IMP-1:0][bsa_pkg::PARAM_W-1:0] parVal;
   logic [NUM_CH-1:0][NUM_IMP-1:0]                     pendOn;
   logic [NUM_CH-1:0][NUM_IMP-1:0]                     pendPar;
   logic [NUM_CH-1:0][NUM_GLAYER-1:0]                  pendAlpha;
   logic [NUM_CH-1:0][NUM_GLAYER-1:0]                  pendPremul;
   logic [bsa_pkg::PARAM_W-1:0]                        parIn;
   logic [bsa_pkg::LIDX_W-1:0]                         impLayer;
   logic                                               impEnabled;
   logic                                               impYcc;
   logic                                               lyrEnabled;

   // improver index picks the layer it serves
   assign impLayer   = {1'b0, qualityImproverIndex};
   assign impEnabled = layerEnabled[cfgChannel][impLayer];
   assign impYcc     = layerFmtYcc[cfgChannel][impLayer];
   assign lyrEnabled = layerEnabled[cfgChannel][graphicsLayerIndex];
   assign parIn      = {darkExpandStartPoint, darkExpandDepth,
                        darkExpandTimeConstFirst, darkExpandTimeConstSecond};

   // ----------------------------------------------------------------
   // command check and next state
   // ----------------------------------------------------------------
   // a refused command changes no setting; the code says why
   always_comb
   begin
      setup_next = setup_reg;
      loadOn     = '0;
      loadPar    = '0;
      loadAlpha  = '0;
      loadPremul = '0;
      setup_next.done = 1'b0;
      if (cfgWrite)
      begin
         setup_next.done = 1'b1;
         case (cfgCmd)
            bsa_pkg::CMD_STRETCH_ON:
            begin
               if (!impEnabled)
                  setup_next.err = bsa_pkg::ERR_RESOURCE;
               else if (cfgStretchOn && !impYcc)
                  setup_next.err = bsa_pkg::ERR_IF_COND;
               else
               begin
                  setup_next.err = bsa_pkg::ERR_NONE;
                  loadOn[cfgChannel][qualityImproverIndex] = 1'b1;
               end
            end
            bsa_pkg::CMD_STRETCH_PARAM:
            begin
               if (!impEnabled)
                  setup_next.err = bsa_pkg::ERR_RESOURCE;
               else if (!impYcc)
                  setup_next.err = bsa_pkg::ERR_IF_COND;
               else if (darkExpandTimeConstSecond > bsa_pkg::TC2_MAX)
                  setup_next.err = bsa_pkg::ERR_RANGE;
               else
               begin
                  setup_next.err = bsa_pkg::ERR_NONE;
                  loadPar[cfgChannel][qualityImproverIndex] = 1'b1;
               end
            end
            bsa_pkg::CMD_ALPHA_1BIT:
            begin
               if (graphicsLayerIndex == bsa_pkg::BASE_LAYER)
                  setup_next.err = bsa_pkg::ERR_GRAPHICS_LAYER_INDEX;
               else if (!lyrEnabled)
                  setup_next.err = bsa_pkg::ERR_RESOURCE;
               else
               begin
                  setup_next.err = bsa_pkg::ERR_NONE;
                  loadAlpha[cfgChannel][graphicsLayerIndex] = 1'b1;
               end
            end
            bsa_pkg::CMD_PREMUL:
            begin
               if (graphicsLayerIndex == bsa_pkg::BASE_LAYER)
                  setup_next.err = bsa_pkg::ERR_GRAPHICS_LAYER_INDEX;
               else if (!lyrEnabled)
                  setup_next.err = bsa_pkg::ERR_RESOURCE;
               else
               begin
                  setup_next.err = bsa_pkg::ERR_NONE;
                  loadPremul[cfgChannel][graphicsLayerIndex] = 1'b1;
               end
            end
            default:
            begin
               setup_next.err = bsa_pkg::ERR_UNDEFINED;
            end
         endcase
      end
      // stretch stays inhibited while the layer format is not YCbCr
      setup_next.gatedOn = rawOn & {layerFmtYcc[1][1:0],
                                    layerFmtYcc[0][1:0]};
      for (int c = 0; c < NUM_CH; c++)
      begin
         setup_next.pendAny[c] = (|pendOn[c]) | (|pendPar[c]) |
                                 (|pendAlpha[c]) | (|pendPremul[c]);
      end
      setup_next.opaque     = bsa_pkg::ALPHA_OPAQUE;
      setup_next.premulBase = '0;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         setup_reg.done       <= 1'b0;
         setup_reg.err        <= bsa_pkg::ERR_NONE;
         setup_reg.pendAny    <= '0;
         setup_reg.gatedOn    <= '0;
         setup_reg.opaque     <= bsa_pkg::ALPHA_OPAQUE;
         setup_reg.premulBase <= '0;
      end
      else
      begin
         setup_reg <= setup_next;
      end
   end

   // ----------------------------------------------------------------
   // per channel black stretch settings
   // ----------------------------------------------------------------
   // each channel commits on its own frame start, never mid-frame
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      for (genvar i = 0; i < NUM_IMP; i++)
      begin : g_imp
         bsa_shadow
         #(
            .W       (1),
            .RST_VAL (bsa_pkg::STRETCH_RST)
         )
         u_on
         (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .load      (loadOn[c][i]),
            .loadData  (cfgStretchOn),
            .commit    (frameStart[c]),
            .activeVal (rawOn[c][i]),
            .pending   (pendOn[c][i])
         );

         bsa_shadow
         #(
            .W       (bsa_pkg::PARAM_W),
            .RST_VAL (bsa_pkg::PARAM_RST)
         )
         u_par
         (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .load      (loadPar[c][i]),
            .loadData  (parIn),
            .commit    (frameStart[c]),
            .activeVal (parVal[c][i]),
            .pending   (pendPar[c][i])
         );

         assign stretchStart[c][i] = parVal[c][i][17:14];
         assign stretchDepth[c][i] = parVal[c][i][13:10];
         assign stretchTc1[c][i]   = parVal[c][i][9:5];
         assign stretchTc2[c][i]   = parVal[c][i][4:0];
      end

      // ------------------------------------------------------------
      // per layer alpha settings, layers 1 to 3
      // ------------------------------------------------------------
      for (genvar l = 1; l < NUM_GLAYER; l++)
      begin : g_lyr
         bsa_shadow
         #(
            .W       (2 * bsa_pkg::ALPHA_W),
            .RST_VAL ({bsa_pkg::ALPHA_RST, bsa_pkg::ALPHA_RST})
         )
         u_alpha
         (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .load      (loadAlpha[c][l]),
            .loadData  ({oneBitAlphaOneValue, oneBitAlphaZeroValue}),
            .commit    (frameStart[c]),
            .activeVal ({alphaOne[c][l], alphaZero[c][l]}),
            .pending   (pendAlpha[c][l])
         );

         bsa_shadow
         #(
            .W       (1),
            .RST_VAL (bsa_pkg::PREMUL_RST)
         )
         u_premul
         (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .load      (loadPremul[c][l]),
            .loadData  (premultiplyEnable),
            .commit    (frameStart[c]),
            .activeVal (premulOn[c][l]),
            .pending   (pendPremul[c][l])
         );
      end

      // layer 0 has no programmable one-bit alpha
      assign alphaZero[c][0]  = setup_reg.opaque;
      assign alphaOne[c][0]   = setup_reg.opaque;
      assign premulOn[c][0]   = setup_reg.premulBase[c];
      assign pendAlpha[c][0]  = 1'b0;
      assign pendPremul[c][0] = 1'b0;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cfgDone       = setup_reg.done;
   assign cfgError      = setup_reg.err;
   assign updatePending = setup_reg.pendAny;
   assign stretchOn     = setup_reg.gatedOn;
   assign outGenAlpha   = setup_reg.opaque;

endmodule

// file: verif/bsa_setup_assertions.sv
// port assertions for the black stretch and alpha setup block
`timescale 1ns/100ps
module bsa_setup_assertions
#(
   parameter int NUM_CH     = bsa_pkg::NUM_CH,
   parameter int NUM_IMP    = bsa_pkg::NUM_IMP,
   parameter int NUM_GLAYER = bsa_pkg::NUM_GLAYER
)
(
   // clock and reset
   input wire logic                              mclk,
   input wire logic                              rst_n,
   // inputs
   input wire logic [NUM_CH-1:0]                 frameStart,
   input wire logic [NUM_CH-1:0][NUM_GLAYER-1:0] layerEnabled,
   input wire logic [NUM_CH-1:0][NUM_GLAYER-1:0] layerFmtYcc,
   input wire logic                              cfgWrite,
   input wire bsa_pkg::bsa_cmd_t                 cfgCmd,
   input wire logic                              cfgChannel,
   input wire logic                              qualityImproverIndex,
   input wire logic [bsa_pkg::LIDX_W-1:0]        graphicsLayerIndex,
   input wire logic [bsa_pkg::TC2_W-1:0]         darkExpandTimeConstSecond,
   // outputs
   input wire logic                              cfgDone,
   input wire bsa_pkg::bsa_err_t                 cfgError,
   input wire logic [NUM_CH-1:0]                 updatePending,
   input wire logic [NUM_CH-1:0][NUM_IMP-1:0]    stretchOn,
   input wire logic [NUM_CH-1:0][NUM_IMP-1:0][3:0] stretchStart,
   input wire logic [NUM_CH-1:0][NUM_IMP-1:0][4:0] stretchTc2,
   input wire logic [NUM_CH-1:0][NUM_GLAYER-1:0][7:0] alphaZero,
   input wire logic [NUM_CH-1:0][NUM_GLAYER-1:0][7:0] alphaOne,
   input wire logic [NUM_CH-1:0][NUM_GLAYER-1:0] premulOn,
   input wire logic [bsa_pkg::ALPHA_W-1:0]       outGenAlpha
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // improver i serves layer i, so only layers 0 and 1 matter here
   wire logic [3:0] yccServed = {layerFmtYcc[1][1:0], layerFmtYcc[0][1:0]};
   wire logic       srvOk = layerEnabled[cfgChannel][qualityImproverIndex]
                            && layerFmtYcc[cfgChannel][qualityImproverIndex];
   wire logic       alphaWr = cfgWrite && cfgCmd == bsa_pkg::CMD_ALPHA_1BIT;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_DONE: assert property (cfgWrite |=> cfgDone)
      else $error("setup write not answered");
   AST_DONE_CAUSE: assert property (cfgDone |-> $past(cfgWrite))
      else $error("answer without setup write");
   AST_L0_FIXED: assert property (alphaZero[0][0] == 8'hff
      && alphaOne[0][0] == 8'hff && alphaZero[1][0] == 8'hff
      && alphaOne[1][0] == 8'hff && outGenAlpha == 8'hff)
      else $error("fixed alpha not opaque");
   AST_L0_PREMUL: assert property (premulOn[0][0] == 1'h0
      && premulOn[1][0] == 1'h0)
      else $error("layer 0 premultiply not off");
   AST_TC2_MAX: assert property (stretchTc2[0][0] <= 5'h1e
      && stretchTc2[0][1] <= 5'h1e && stretchTc2[1][0] <= 5'h1e
      && stretchTc2[1][1] <= 5'h1e)
      else $error("second time constant above limit");
   AST_RANGE: assert property (cfgWrite && srvOk
      && cfgCmd == bsa_pkg::CMD_STRETCH_PARAM
      && darkExpandTimeConstSecond > 5'h1e |=> cfgError == bsa_pkg::ERR_RANGE)
      else $error("range error missing");
   AST_GRAPHICS_LAYER_INDEX: assert property (alphaWr && graphicsLayerIndex == 2'h0
      && layerEnabled[cfgChannel][0] |=> cfgError == bsa_pkg::ERR_GRAPHICS_LAYER_INDEX)
      else $error("graphics_layer_index error missing");
   AST_RESOURCE: assert property (alphaWr && graphicsLayerIndex != 2'h0
      && !layerEnabled[cfgChannel][graphicsLayerIndex]
      |=> cfgError == bsa_pkg::ERR_RESOURCE)
      else $error("resource error missing");
   AST_INHIBIT: assert property ((stretchOn & ~$past(yccServed)) == 4'h0)
      else $error("stretch on for non ycc layer");
   AST_FRAME_HOLD: assert property (!frameStart[0] |=> $stable(alphaZero[0])
      && $stable(alphaOne[0]) && $stable(premulOn[0])
      && $stable(stretchStart[0]) && $stable(stretchTc2[0]))
      else $error("settings changed outside frame start");
   AST_PENDING: assert property (alphaWr && !cfgChannel
      && graphicsLayerIndex != 2'h0 && layerEnabled[0][graphicsLayerIndex]
      |=> ##1 updatePending[0])
      else $error("accepted write not pending");

   COV_RANGE: cover property (cfgDone && cfgError == bsa_pkg::ERR_RANGE);
   COV_ALPHA: cover property (alphaWr && graphicsLayerIndex == 2'h2);
   COV_APPLY: cover property (frameStart[0] && updatePending[0]);
endmodule

bind bsa_setup bsa_setup_assertions
#(.NUM_CH(NUM_CH), .NUM_IMP(NUM_IMP), .NUM_GLAYER(NUM_GLAYER)) i_chk
(
   .mclk, .rst_n, .frameStart, .layerEnabled, .layerFmtYcc, .cfgWrite,
   .cfgCmd, .cfgChannel, .qualityImproverIndex, .graphicsLayerIndex,
   .darkExpandTimeConstSecond, .cfgDone, .cfgError, .updatePending,
   .stretchOn, .stretchStart, .stretchTc2, .alphaZero, .alphaOne,
   .premulOn, .outGenAlpha
);

// file: verif/bsa_setup_tb.sv
// self-checking bench for the black stretch and alpha setup block
`timescale 1ns/100ps
module bsa_setup_tb;
   typedef struct {
      bsa_pkg::bsa_cmd_t cmd;
      logic              ch;
      logic [1:0]        idx;
      logic [17:0]       prm;
      logic [15:0]       alp;
      bsa_pkg::bsa_err_t err;
   } bsa_row_t;

   logic                  mclk, rst_n, cfgWrite, cfgChannel, qIdx, cfgOn, pmEn;
   logic [1:0]            frameStart, lIdx;
   logic [1:0][3:0]       layerEnabled, layerFmtYcc;
   bsa_pkg::bsa_cmd_t     cfgCmd;
   logic [17:0]           prm;
   logic [15:0]           alp;
   logic                  cfgDone;
   bsa_pkg::bsa_err_t     cfgError;
   logic [1:0]            updatePending;
   logic [1:0][1:0]       stretchOn;
   logic [1:0][1:0][3:0]  stretchStart, stretchDepth;
   logic [1:0][1:0][4:0]  stretchTc1, stretchTc2;
   logic [1:0][3:0][7:0]  alphaZero, alphaOne;
   logic [1:0][3:0]       premulOn;
   logic [7:0]            outGenAlpha;
   logic                  mOn[2][2] = '{default: 1'h0};
   logic [17:0]           mPrm[2][2] = '{default: 18'h0};
   logic [15:0]           mAlp[2][4] = '{2{'{16'hffff, 16'h0, 16'h0, 16'h0}}};
   logic                  mPm[2][4] = '{default: 1'h0};
   int                    errCount, testsRun, cycles;
   localparam bsa_pkg::bsa_cmd_t ON = bsa_pkg::CMD_STRETCH_ON,
      PAR = bsa_pkg::CMD_STRETCH_PARAM, ALP = bsa_pkg::CMD_ALPHA_1BIT,
      PM = bsa_pkg::CMD_PREMUL, BAD = bsa_pkg::bsa_cmd_t'(4'h3);
   localparam bsa_pkg::bsa_err_t OK = bsa_pkg::ERR_NONE;

   // rows run back to back; refused rows must leave the model untouched
   bsa_row_t rows[13] = '{
      '{ON,1'h0,2'h0,18'h1,16'h0,OK},
      '{PAR,1'h0,2'h0,18'h3fffe,16'h0,OK},
      '{PAR,1'h0,2'h1,18'h0487f,16'h0,bsa_pkg::ERR_RANGE},
      '{PAR,1'h1,2'h0,18'h16800,16'h0,OK},
      '{ON,1'h1,2'h1,18'h1,16'h0,bsa_pkg::ERR_IF_COND},
      '{ON,1'h1,2'h1,18'h0,16'h0,OK},
      '{ALP,1'h0,2'h1,18'h0,16'h00ff,OK},
      '{ALP,1'h1,2'h3,18'h0,16'h1234,bsa_pkg::ERR_RESOURCE},
      '{ALP,1'h1,2'h2,18'h0,16'h5aa5,OK},
      '{PM,1'h0,2'h3,18'h0,16'h0001,OK},
      '{ALP,1'h1,2'h0,18'h0,16'h1111,bsa_pkg::ERR_GRAPHICS_LAYER_INDEX},
      '{BAD,1'h0,2'h1,18'h0,16'h0,bsa_pkg::ERR_UNDEFINED},
      '{ON,1'h0,2'h1,18'h1,16'h0,OK}
   };

   bsa_setup i_dut
   (
      .mclk, .rst_n, .frameStart, .layerEnabled, .layerFmtYcc, .cfgWrite,
      .cfgCmd, .cfgChannel, .qualityImproverIndex(qIdx),
      .graphicsLayerIndex(lIdx), .cfgStretchOn(cfgOn),
      .darkExpandStartPoint(prm[17:14]), .darkExpandDepth(prm[13:10]),
      .darkExpandTimeConstFirst(prm[9:5]),
      .darkExpandTimeConstSecond(prm[4:0]),
      .oneBitAlphaZeroValue(alp[15:8]), .oneBitAlphaOneValue(alp[7:0]),
      .premultiplyEnable(pmEn), .cfgDone, .cfgError, .updatePending,
      .stretchOn, .stretchStart, .stretchDepth, .stretchTc1, .stretchTc2,
      .alphaZero, .alphaOne, .premulOn, .outGenAlpha
   );

   // ----------------------------------------------------------------
   // clock, timeout and helpers
   // ----------------------------------------------------------------
   always #12.5 mclk = ~mclk;

   // whole run is under a hundred cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         errCount++;
         printVerdict();
      end
   end

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         errCount++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic printVerdict();
      $display("checks %0d mismatches %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic drive(bsa_row_t r);
      cfgWrite = 1'h1;
      cfgCmd = r.cmd;
      cfgChannel = r.ch;
      qIdx = r.idx[0];
      lIdx = r.idx;
      cfgOn = r.prm[0];
      prm = r.prm;
      alp = r.alp;
      pmEn = r.alp[0];
      if (r.err == OK)
         case (r.cmd)
            ON: mOn[r.ch][r.idx[0]] = r.prm[0];
            PAR: mPrm[r.ch][r.idx[0]] = r.prm;
            ALP: mAlp[r.ch][r.idx] = r.alp;
            default: mPm[r.ch][r.idx] = r.alp[0];
         endcase
   endtask

   task automatic frame(logic [1:0] f);
      @(negedge mclk) frameStart = f;
      @(negedge mclk) frameStart = 2'h0;
      repeat (2) @(negedge mclk);
   endtask

   task automatic reset_chk();
      check("error", cfgError, bsa_pkg::ERR_NONE);
      check("start", stretchStart[1][1], 32'h0);
      check("depth", stretchDepth[0][1], 32'h0);
      check("tc1", stretchTc1[1][0], 32'h0);
      check("tc2", stretchTc2[0][0], 32'h0);
      check("a0", alphaZero[0][2], 32'h0);
      check("a1", alphaOne[1][3], 32'h0);
      check("gen", outGenAlpha, 32'hff);
      check("premul", premulOn, 32'h0);
      check("pend", updatePending, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'h0;
      rst_n = 1'h0;
      frameStart = 2'h0;
      drive('{ON,1'h0,2'h0,18'h0,16'h0,OK});
      layerEnabled = 8'h7f;
      layerFmtYcc = 8'h13;
      repeat (2) @(negedge mclk);
      rst_n = 1'h1;
      cfgWrite = 1'h0;
      reset_chk();
      for (int n = 0; n <= 13; n++)
      begin
         @(negedge mclk);
         if (n > 0)
         begin
            check("done", cfgDone, 32'h1);
            check("err", cfgError, rows[n-1].err);
         end
         if (n == 13)
            cfgWrite = 1'h0;
         else
            drive(rows[n]);
      end
      check("hold", stretchStart[0][0], 32'h0);
      check("pend", updatePending, 32'h3);
      frame(2'h3);
      check("pend", updatePending, 32'h0);
      foreach (mPrm[c, i])
      begin
         check("prm", {stretchStart[c][i], stretchDepth[c][i],
                       stretchTc1[c][i], stretchTc2[c][i]}, mPrm[c][i]);
         check("on", stretchOn[c][i], mOn[c][i] & layerFmtYcc[c][i]);
      end
      foreach (mAlp[c, l])
      begin
         check("alpha", {alphaZero[c][l], alphaOne[c][l]}, mAlp[c][l]);
         check("pm", premulOn[c][l], mPm[c][l]);
      end
      layerFmtYcc[0][0] = 1'h0;
      repeat (2) @(negedge mclk);
      check("inhibit", stretchOn[0][0], 32'h0);
      // write on the frame edge, then an overwrite, then another channel
      drive('{ALP,1'h0,2'h2,18'h0,16'h2200,OK});
      frameStart = 2'h1;
      @(negedge mclk) frameStart = 2'h0;
      drive('{ALP,1'h0,2'h2,18'h0,16'h3300,OK});
      @(negedge mclk);
      drive('{ALP,1'h1,2'h1,18'h0,16'h4400,OK});
      @(negedge mclk) cfgWrite = 1'h0;
      check("same", alphaZero[0][2], 32'h0);
      frame(2'h1);
      check("last", alphaZero[0][2], 32'h33);
      check("other", alphaZero[1][1], 32'h0);
      check("pend", updatePending, 32'h2);
      rst_n = 1'h0;
      repeat (2) @(negedge mclk);
      rst_n = 1'h1;
      reset_chk();
      printVerdict();
   end
endmodule
